// ---- shared/ext_osc_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants, types and helpers for the external oscillator control
// Assumes: 20 MHz core clock, APB register access with 32-bit data
// Notes:   register indices are word indices, byte address is index times 4
//
// Operation
// RULE1: both CMOS clock modes always read the valid flag as zero.
// RULE2: other modes: valid is 0 when unused or unstable, 1 when stable.
// RULE3: mode 00x is off, 010 CMOS clock, 011 CMOS clock divided by 2.
// RULE4: mode 100 is RC divided by 2, 101 is capacitor divided by 2.
// RULE5: mode 110 is crystal undivided, 111 is crystal divided by 2.
// RULE6: any divide-by-2 stage delivers a clock with 50% duty cycle.
// RULE7: unused bit 3 reads zero and writes to it are ignored.
// RULE8: software picks crystal mode and a range matching the crystal.
// RULE9: after enabling the crystal, hardware offers a pollable valid flag.
// RULE10: software sets both pins analog with output drivers disabled first.
// RULE11: software waits 1 ms, polls valid, then switches system clock.
// RULE12: software never switches to the oscillator before it is stable.
// RULE13: the range field picks frequency bands, e.g. 011 for 155-415 kHz.
// RULE14: writes to the valid bit are ignored; it clears on reset.
//////////////////////////////////////////////////////////////////////////////
package ext_osc_pkg;

   localparam logic [11:0] CTRL_INDEX       = 12'h0b1;
   localparam logic [11:0] IRQ_STATUS_INDEX = 12'h0b2;
   localparam logic [11:0] IRQ_MASK_INDEX   = 12'h0b3;
   localparam logic [11:0] CTRL_ADDR        = {CTRL_INDEX[9:0], 2'b00};
   localparam logic [11:0] IRQ_STATUS_ADDR  = {IRQ_STATUS_INDEX[9:0], 2'b00};
   localparam logic [11:0] IRQ_MASK_ADDR    = {IRQ_MASK_INDEX[9:0], 2'b00};

   localparam int          VALID_BIT   = 7;
   localparam int          MODE_LSB    = 4;
   localparam int          UNUSED_BIT  = 3;
   localparam int          FREQ_LSB    = 0;
   localparam logic [7:0]  CTRL_RESET  = 8'h00;

   localparam int          IRQ_W        = 2;
   localparam int          IRQ_VALID_UP = 0;
   localparam int          IRQ_VALID_DN = 1;
   localparam logic [1:0]  IRQ_RESET    = 2'h0;

   localparam int          CLK_PERIOD_NS = 50;
   localparam int          GAP_TIME_NS   = 100000;
   localparam logic [15:0] GAP_CYCLES    = 16'(GAP_TIME_NS / CLK_PERIOD_NS);
   localparam logic [15:0] STABLE_EDGES  = 16'h0400;

   typedef enum logic [2:0] {
      MODE_OFF       = 3'b000,
      MODE_CMOS      = 3'b010,
      MODE_CMOS_DIV2 = 3'b011,
      MODE_RC_DIV2   = 3'b100,
      MODE_CAP_DIV2  = 3'b101,
      MODE_XTAL      = 3'b110,
      MODE_XTAL_DIV2 = 3'b111
   } mode_t;

   typedef enum logic [1:0] {
      DET_IDLE   = 2'b00,
      DET_SETTLE = 2'b01,
      DET_STABLE = 2'b11
   } det_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   function automatic mode_t decode_mode(input logic [2:0] code);
      mode_t m;
      case (code)
         3'b010:  m = MODE_CMOS;
         3'b011:  m = MODE_CMOS_DIV2;
         3'b100:  m = MODE_RC_DIV2;
         3'b101:  m = MODE_CAP_DIV2;
         3'b110:  m = MODE_XTAL;
         3'b111:  m = MODE_XTAL_DIV2;
         default: m = MODE_OFF;
      endcase
      return m;
   endfunction : decode_mode

   function automatic logic is_cmos(input mode_t m);
      return (m == MODE_CMOS) || (m == MODE_CMOS_DIV2);
   endfunction : is_cmos

   function automatic logic is_divided(input mode_t m);
      return (m != MODE_OFF) && (m != MODE_CMOS) && (m != MODE_XTAL);
   endfunction : is_divided

   function automatic logic is_oscillating(input mode_t m);
      return (m != MODE_OFF) && !is_cmos(m);
   endfunction : is_oscillating

endpackage : ext_osc_pkg

// ---- hdl/osc_valid_detector.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: decides when the external oscillator is running and stable
// Assumes: pin rise pulses are synchronous one-cycle pulses
// Notes:   stable after a run of edges, each within the gap limit
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module osc_valid_detector (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic enable_i,
   input  wire logic restart_i,
   input  wire logic pin_rise_i,
   output logic      valid_o
);
   import ext_osc_pkg::*;

   det_state_t  state_q;
   logic [15:0] gap_q;
   logic [15:0] edges_q;
   logic        gap_hit;

   assign gap_hit = (gap_q >= GAP_CYCLES);

   // a long gap restarts the count, so a stalled crystal drops valid
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= DET_IDLE;
         gap_q   <= 16'h0000;
         edges_q <= 16'h0000;
      end else if (!enable_i || restart_i) begin
         state_q <= DET_IDLE; // RULE9
         gap_q   <= 16'h0000;
         edges_q <= 16'h0000;
      end else begin
         gap_q <= pin_rise_i ? 16'h0000 : (gap_hit ? gap_q : gap_q + 16'h0001);
         case (state_q)
            DET_IDLE: begin
               edges_q <= 16'h0000;
               if (pin_rise_i) begin
                  state_q <= DET_SETTLE;
               end
            end
            DET_SETTLE: begin
               if (gap_hit) begin
                  state_q <= DET_IDLE;
               end else if (pin_rise_i) begin
                  edges_q <= edges_q + 16'h0001;
                  if (edges_q == STABLE_EDGES - 16'h0001) begin
                     state_q <= DET_STABLE; // RULE2
                  end
               end
            end
            DET_STABLE: begin
               if (gap_hit) begin
                  state_q <= DET_IDLE;
               end
            end
            default: state_q <= DET_IDLE;
         endcase
      end
   end

   assign valid_o = (state_q == DET_STABLE);

   chk_restart_clears_valid : assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (restart_i || !enable_i) |=> !valid_o) // RULE9
      else $error("valid stayed set after detector restart");

endmodule : osc_valid_detector

// ---- hdl/ext_clk_div.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: delivers the external clock, straight or halved
// Assumes: pin level and rise pulse are synchronous to the core clock
// Notes:   halving toggles on rising edges only, giving an even duty cycle
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module ext_clk_div (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic enable_i,
   input  wire logic divide_i,
   input  wire logic pin_i,
   input  wire logic pin_rise_i,
   output logic      clk_o,
   output logic      tick_o
);
   logic clk_q;
   logic tick_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_q  <= 1'b0;
         tick_q <= 1'b0;
      end else if (!enable_i) begin
         clk_q  <= 1'b0;
         tick_q <= 1'b0;
      end else if (divide_i) begin
         // toggling once per source period makes high and low equal
         clk_q  <= pin_rise_i ? !clk_q : clk_q; // RULE6
         tick_q <= pin_rise_i && !clk_q;
      end else begin
         clk_q  <= pin_i;
         tick_q <= pin_rise_i;
      end
   end

   assign clk_o  = clk_q;
   assign tick_o = tick_q;

   chk_div_toggle_rise : assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (enable_i && $past(enable_i) && divide_i && $past(divide_i)
       && $changed(clk_q)) |-> $past(pin_rise_i)) // RULE6
      else $error("halved clock changed without a source rising edge");

endmodule : ext_clk_div

// ---- hdl/external_oscillator_control.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: control register, valid flag and clock delivery for the
//          external oscillator drive circuit
// Assumes: pin input is synchronous to the core clock; APB slave, no waits
// Notes:   analog drive and system clock switching live elsewhere
//////////////////////////////////////////////////////////////////////////////
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module external_oscillator_control (
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   input  wire ext_osc_pkg::apb_req_t apb_req_i,
   output ext_osc_pkg::apb_rsp_t     apb_rsp_o,
   input  wire logic                 osc_pin_input_i,
   output ext_osc_pkg::mode_t        ext_osc_mode_select_o,
   output logic [2:0]                ext_osc_freq_range_o,
   output logic                      osc_circuit_on_o,
   output logic                      ext_clk_o,
   output logic                      ext_clk_tick_o,
   output logic                      crystal_valid_poll_o,
   output logic                      irq_o
);
   import ext_osc_pkg::*;

   ///////////////////////////////////////////////////////////////////////////
   // declarations
   logic [2:0]       mode_code_q;
   logic [2:0]       freq_range_q;
   mode_t            mode;
   logic             pin_prev_q;
   logic             pin_rise;
   logic             det_valid;
   logic             det_restart;
   logic             ext_osc_valid_flag;
   logic             valid_prev_q;
   logic [IRQ_W-1:0] irq_status_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_events;
   logic [31:0]      prdata_q;
   logic             pslverr_q;
   logic [31:0]      rd_value;
   logic             rd_mapped;
   logic             setup;
   logic             access;
   logic             wr_ctrl;
   logic             wr_status;
   logic             wr_mask;
   logic [7:0]       ctrl_view;

   ///////////////////////////////////////////////////////////////////////////
   // apb decode
   assign setup     = apb_req_i.psel && !apb_req_i.penable;
   assign access    = apb_req_i.psel && apb_req_i.penable;
   assign wr_ctrl   = access && apb_req_i.pwrite
                      && (apb_req_i.paddr == CTRL_ADDR);
   assign wr_status = access && apb_req_i.pwrite
                      && (apb_req_i.paddr == IRQ_STATUS_ADDR);
   assign wr_mask   = access && apb_req_i.pwrite
                      && (apb_req_i.paddr == IRQ_MASK_ADDR);

   ///////////////////////////////////////////////////////////////////////////
   // control register: mode and range are writable, bits 7 and 3 are not
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_code_q  <= CTRL_RESET[MODE_LSB +: 3];
         freq_range_q <= CTRL_RESET[FREQ_LSB +: 3];
      end else if (wr_ctrl) begin
         mode_code_q  <= apb_req_i.pwdata[MODE_LSB +: 3];
         freq_range_q <= apb_req_i.pwdata[FREQ_LSB +: 3]; // RULE8
      end
   end

   // RULE3 RULE4 RULE5
   assign mode = decode_mode(mode_code_q);

   // a new mode restarts stability tracking from scratch
   assign det_restart = wr_ctrl
                        && (apb_req_i.pwdata[MODE_LSB +: 3] != mode_code_q);

   ///////////////////////////////////////////////////////////////////////////
   // pin edge and valid detection
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= osc_pin_input_i;
      end
   end

   assign pin_rise = osc_pin_input_i && !pin_prev_q;

   osc_valid_detector u_detector (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .enable_i   (is_oscillating(mode)),
      .restart_i  (det_restart),
      .pin_rise_i (pin_rise),
      .valid_o    (det_valid)
   );

   // cmos and off modes never report valid, whatever the pin does
   // RULE1 RULE2 RULE14
   assign ext_osc_valid_flag = det_valid && is_oscillating(mode);

   ///////////////////////////////////////////////////////////////////////////
   // clock delivery
   ext_clk_div u_divider (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .enable_i   (mode != MODE_OFF),
      .divide_i   (is_divided(mode)),
      .pin_i      (osc_pin_input_i),
      .pin_rise_i (pin_rise),
      .clk_o      (ext_clk_o),
      .tick_o     (ext_clk_tick_o)
   );

   ///////////////////////////////////////////////////////////////////////////
   // interrupts: valid gained and valid lost, write one to clear
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_prev_q <= 1'b0;
      end else begin
         valid_prev_q <= ext_osc_valid_flag;
      end
   end

   always_comb begin
      irq_events               = '0;
      irq_events[IRQ_VALID_UP] = ext_osc_valid_flag && !valid_prev_q;
      irq_events[IRQ_VALID_DN] = !ext_osc_valid_flag && valid_prev_q;
   end

   // set beats clear so an event landing on a clear write is kept
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_status_q <= IRQ_RESET;
      end else begin
         irq_status_q <= (irq_status_q
                          & ~(wr_status ? apb_req_i.pwdata[IRQ_W-1:0] : '0))
                         | irq_events;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_mask_q <= IRQ_RESET;
      end else if (wr_mask) begin
         irq_mask_q <= apb_req_i.pwdata[IRQ_W-1:0];
      end
   end

   assign irq_o = |(irq_status_q & irq_mask_q);

   ///////////////////////////////////////////////////////////////////////////
   // read path, captured in the setup cycle and returned in the access cycle
   always_comb begin
      ctrl_view                   = '0;
      ctrl_view[VALID_BIT]        = ext_osc_valid_flag; // RULE14
      ctrl_view[MODE_LSB +: 3]    = mode_code_q;
      ctrl_view[UNUSED_BIT]       = 1'b0; // RULE7
      ctrl_view[FREQ_LSB +: 3]    = freq_range_q;
      rd_value  = 32'h0000_0000;
      rd_mapped = 1'b1;
      case (apb_req_i.paddr)
         CTRL_ADDR:       rd_value = {24'h00_0000, ctrl_view};
         IRQ_STATUS_ADDR: rd_value = {30'h0000_0000, irq_status_q};
         IRQ_MASK_ADDR:   rd_value = {30'h0000_0000, irq_mask_q};
         default:         rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= apb_req_i.pwrite ? 32'h0000_0000 : rd_value;
         pslverr_q <= !rd_mapped;
      end
   end

   // unmapped addresses answer with an error and no side effect
   always_comb begin
      apb_rsp_o.prdata  = prdata_q;
      apb_rsp_o.pready  = access;
      apb_rsp_o.pslverr = access && pslverr_q;
   end

   ///////////////////////////////////////////////////////////////////////////
   // outputs
   assign ext_osc_mode_select_o = mode;
   assign ext_osc_freq_range_o  = freq_range_q;
   assign osc_circuit_on_o      = (mode != MODE_OFF);
   assign crystal_valid_poll_o  = ext_osc_valid_flag; // RULE9

   ///////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_ctrl_setup;
      setup && (apb_req_i.paddr == CTRL_ADDR);
   endsequence

   sequence s_ctrl_read;
      (s_ctrl_setup and !apb_req_i.pwrite) ##1 access;
   endsequence

   chk_cmos_valid_low : assert property ( // RULE1
      is_cmos(mode) |-> !crystal_valid_poll_o && !ctrl_view[VALID_BIT])
      else $error("valid flag set in a cmos clock mode");

   chk_off_valid_low : assert property ( // RULE2
      (mode_code_q[2:1] == 2'b00) |-> !crystal_valid_poll_o)
      else $error("valid flag set while the oscillator is off");

   // valid may only appear on the pin edge that completes the run
   chk_valid_rise_edge : assert property ( // RULE2
      $rose(crystal_valid_poll_o) |-> $past(pin_rise))
      else $error("valid flag rose without a pin edge");

   chk_mode_cmos_decode : assert property ( // RULE3
      (mode_code_q == 3'b011) |-> (ext_osc_mode_select_o == MODE_CMOS_DIV2)
                                  && ($past(mode_code_q) != 3'b011
                                      || ext_clk_o == $past(ext_clk_o)
                                      || $past(pin_rise)))
      else $error("cmos divided mode decoded wrongly");

   chk_mode_rc_decode : assert property ( // RULE4
      (mode_code_q == 3'b100) |-> is_divided(ext_osc_mode_select_o)
                                   && osc_circuit_on_o)
      else $error("rc mode not decoded as divided and on");

   chk_mode_xtal_decode : assert property ( // RULE5
      (mode_code_q == 3'b110) |-> (ext_osc_mode_select_o == MODE_XTAL)
                                   && !is_divided(ext_osc_mode_select_o))
      else $error("crystal mode decoded wrongly");

   chk_bit3_reads_zero : assert property ( // RULE7
      s_ctrl_read |-> (apb_rsp_o.prdata[UNUSED_BIT] == 1'b0)
                      && !apb_rsp_o.pslverr)
      else $error("unused control bit read back as one");

   chk_valid_wr_ignored : assert property ( // RULE14
      (wr_ctrl && apb_req_i.pwdata[VALID_BIT] && !det_valid && !pin_rise)
      |=> !crystal_valid_poll_o)
      else $error("software write set the valid flag");

   chk_mode_change_drops : assert property ( // RULE9
      det_restart |=> !crystal_valid_poll_o [*2])
      else $error("valid flag survived a mode change");

   chk_range_written : assert property ( // RULE8
      wr_ctrl |=> ext_osc_freq_range_o == $past(apb_req_i.pwdata[2:0]))
      else $error("frequency range write not stored");

   chk_valid_up_irq : assert property (
      (crystal_valid_poll_o && !valid_prev_q) |=> irq_status_q[IRQ_VALID_UP])
      else $error("valid rise did not set its status bit");

endmodule : external_oscillator_control

// ---- verification/ext_osc_source_model.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: stand-in for the crystal, rc/c network or cmos clock at the pin
// Assumes: pin level is produced on the core clock grid
// Notes:   half period in core cycles, so slow and fast sources both fit
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module ext_osc_source_model (
   input  wire logic       core_clk_i,
   input  wire logic       run_i,
   input  wire logic [7:0] half_i,
   output logic            pin_o
);
   logic [7:0] cnt_q;

   // a stopped source stands still low, like a crystal with no drive
   always_ff @(posedge core_clk_i) begin
      if (!run_i) begin
         cnt_q <= 8'h00;
         pin_o <= 1'b0;
      end else if (cnt_q + 8'h01 >= half_i) begin
         cnt_q <= 8'h00;
         pin_o <= ~pin_o;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule : ext_osc_source_model

// ---- verification/testbench.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the external oscillator control block
// Assumes: zero-wait apb slave, pin source with a 4-cycle period
// Notes:   each scenario is its own task; run is about 50k cycles
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module testbench;
   import ext_osc_pkg::*;
   logic       core_clk_i;
   logic       rst_n_i;
   logic       pin;
   logic       run;
   apb_req_t   req;
   apb_rsp_t   rsp;
   mode_t      mode;
   logic [2:0] range;
   logic       on;
   logic       eclk;
   logic       vld;
   logic       irq;
   logic       tick;
   logic [31:0] rd;
   int         n_mismatch;
   int         compares;

   external_oscillator_control u_external_oscillator_control (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .apb_req_i(req),
      .apb_rsp_o(rsp), .osc_pin_input_i(pin), .ext_osc_mode_select_o(mode),
      .ext_osc_freq_range_o(range), .osc_circuit_on_o(on), .ext_clk_o(eclk),
      .ext_clk_tick_o(tick), .crystal_valid_poll_o(vld), .irq_o(irq));
   ext_osc_source_model u_ext_osc_source_model (
      .core_clk_i(core_clk_i), .run_i(run), .half_i(8'h02), .pin_o(pin));

   //////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got,
                  exp);
      end
   endtask : check

   // entered just after a rising edge; holds the request until pready
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= wd;
      @(posedge core_clk_i);
      req.penable <= 1'b1;
      // no local limit: only the watchdog ends a wait for pready
      do begin
         @(posedge core_clk_i);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      check(32'(rsp.pslverr), 32'(a == 12'h000), "bus error flag");
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      @(posedge core_clk_i);
   endtask : apb

   task automatic measure(output int hi, output int rises,
                          output int ticks);
      logic prev;
      hi = 0;
      rises = 0;
      ticks = 0;
      prev = eclk;
      repeat (160) begin
         @(posedge core_clk_i);
         hi += int'(eclk === 1'b1);
         rises += int'(eclk === 1'b1 && prev === 1'b0);
         ticks += int'(tick === 1'b1);
         prev = eclk;
      end
   endtask : measure

   //////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      apb(1'b0, CTRL_ADDR, 32'h0);
      check(rd, 32'h0, "control after reset");
      apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
      check(rd, 32'h0, "status after reset");
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h0, "unmapped read data");
   endtask : t_reset

   // every mode code, with bits 7 and 3 forced high on the write
   task automatic t_decode();
      mode_t exp_m [8] = '{MODE_OFF, MODE_OFF, MODE_CMOS, MODE_CMOS_DIV2,
         MODE_RC_DIV2, MODE_CAP_DIV2, MODE_XTAL, MODE_XTAL_DIV2};
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         apb(1'b1, CTRL_ADDR, {24'h0, 1'b1, c, 1'b1, 3'h5});
         check(32'(mode), 32'(exp_m[i]), "mode decode");
         check(32'(on), 32'(i > 1), "circuit on");
         check(32'(range), 32'h5, "range output");
         apb(1'b0, CTRL_ADDR, 32'h0);
         check(rd, {24'h0, 1'b0, c, 1'b0, 3'h5}, "readback");
      end
   endtask : t_decode

   task automatic t_crystal();
      apb(1'b1, IRQ_MASK_ADDR, 32'h1);
      apb(1'b1, CTRL_ADDR, 32'h63);
      run <= 1'b1;
      repeat (20000) @(posedge core_clk_i);
      apb(1'b0, CTRL_ADDR, 32'h0);
      repeat (100) if (rd[7] !== 1'b1) apb(1'b0, CTRL_ADDR, 32'h0);
      check(rd, 32'he3, "valid after start");
      check(32'(irq), 32'h1, "irq on valid gained");
      apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
      check(32'(irq), 32'h0, "irq after clear");
   endtask : t_crystal

   task automatic t_divided();
      int hi;
      int rises;
      int ticks;
      apb(1'b1, CTRL_ADDR, 32'h73);
      check(32'(vld), 32'h0, "valid drops on mode change");
      apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
      check(rd, 32'h2, "valid lost status");
      check(32'(irq), 32'h0, "lost event masked");
      apb(1'b1, IRQ_MASK_ADDR, 32'h2);
      check(32'(irq), 32'h1, "lost event unmasked");
      apb(1'b1, IRQ_STATUS_ADDR, 32'h2);
      check(32'(irq), 32'h0, "lost event cleared");
      repeat (6000) @(posedge core_clk_i);
      check(32'(vld), 32'h1, "valid in divided crystal mode");
      measure(hi, rises, ticks);
      check(32'(hi), 32'd80, "divided duty");
      check(32'(rises), 32'd20, "divided rises");
      check(32'(ticks), 32'd20, "divided ticks");
      run <= 1'b0;
      repeat (2100) @(posedge core_clk_i);
      check(32'(vld), 32'h0, "valid after source stops");
   endtask : t_divided

   // source running all along, yet both clock-input modes read invalid
   task automatic t_cmos();
      int seen;
      int hi;
      int rises;
      int ticks;
      run <= 1'b1;
      for (int i = 2; i < 4; i++) begin
         seen = 0;
         apb(1'b1, CTRL_ADDR, {24'h0, 1'b0, 3'(i), 4'h0});
         repeat (6000) begin
            @(posedge core_clk_i);
            seen += int'(vld !== 1'b0);
         end
         check(32'(seen), 32'h0, "valid in clock input mode");
         apb(1'b0, CTRL_ADDR, 32'h0);
         check(32'(rd[7]), 32'h0, "valid bit in clock input mode");
      end
      measure(hi, rises, ticks);
      check(32'(hi), 32'd80, "clock input divided duty");
      check(32'(ticks), 32'd20, "clock input divided ticks");
   endtask : t_cmos

   // a reset in mid-run drops a stable valid flag at once
   task automatic t_reset_mid();
      apb(1'b1, CTRL_ADDR, 32'h63);
      repeat (6000) @(posedge core_clk_i);
      check(32'(vld), 32'h1, "valid before mid-run reset");
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      check(32'(vld), 32'h0, "valid during reset");
      check(32'(irq), 32'h0, "irq during reset");
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      apb(1'b0, CTRL_ADDR, 32'h0);
      check(rd, 32'h0, "control after mid-run reset");
      apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
      check(rd, 32'h0, "status after mid-run reset");
   endtask : t_reset_mid

   //////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk_i = 1'b0;
      forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
   end

   initial begin
      #(CLK_PERIOD_NS * 80000);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      n_mismatch = 0;
      compares = 0;
      rst_n_i = 1'b0;
      run = 1'b0;
      req = '0;
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      t_reset();
      t_decode();
      t_crystal();
      t_divided();
      t_cmos();
      t_reset_mid();
      wrap_up();
   end
endmodule : testbench
